// file: bench/bdpwm_chk.sv
// Purpose: Port level checks for the burst dimming PWM
// Assumes: Internal tick divider of 4 or more sys_clk cycles
// Notes: The DAC count is hidden, so bounds are given in sys_clk cycles
`timescale 1ns/1ps
module bdpwm_chk (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] brightness_level_in,
  input wire logic startup_mask_timer_pin,
  input wire logic open_lamp_sense_in,
  input wire logic startup_mask_discharge,
  input wire logic lamp_drive_out,
  input wire logic open_lamp_fault,
  input wire logic startup_done
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_first_on: assert property ($rose(rst_n) |=> lamp_drive_out)
    else $error("drive low after reset release");
  chk_min_width: assert property ($rose(lamp_drive_out) |-> lamp_drive_out [*8])
    else $error("drive pulse too short");
  chk_fault_off: assert property (open_lamp_fault |=> !lamp_drive_out)
    else $error("drive on during fault");
  chk_fault_held: assert property (open_lamp_fault |=> open_lamp_fault)
    else $error("fault cleared without reset");
  chk_mask_first: assert property ($rose(open_lamp_fault) |-> $past(startup_done))
    else $error("fault before startup delay ended");
  chk_done_cause: assert property ($rose(startup_done) |-> $past(startup_mask_timer_pin, 3))
    else $error("done without timer crossing");
  chk_dis_done: assert property (startup_mask_discharge == startup_done)
    else $error("discharge differs from done latch");
  // A seen crossing must be latched three cycles later: two synchroniser stages, then the latch
  chk_cross_done: assert property ($past(startup_mask_timer_pin, 3) |->
    startup_done)
    else $error("timer crossing not latched");
  chk_sense_gate: assert property ($rose(open_lamp_fault) |->
    lamp_drive_out && $past(open_lamp_sense_in, 3))
    else $error("fault outside on-time or without sense");
  chk_sense_delay: assert property ($rose(lamp_drive_out) |=> !open_lamp_fault [*8])
    else $error("fault too soon after rising edge");
  // 48 ticks of at least 4 cycles each put the drive high well before any fault
  chk_sense_late: assert property ($rose(open_lamp_fault) |->
    $past(lamp_drive_out, 150))
    else $error("fault without long enough on-time");
  chk_low_duty: assert property ($rose(open_lamp_fault) |-> brightness_level_in >= 8'h20)
    else $error("fault at low duty");
endmodule
bind bdpwm_top bdpwm_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .brightness_level_in(brightness_level_in), .startup_mask_timer_pin(startup_mask_timer_pin),
  .open_lamp_sense_in(open_lamp_sense_in), .startup_mask_discharge(startup_mask_discharge),
  .lamp_drive_out(lamp_drive_out), .open_lamp_fault(open_lamp_fault),
  .startup_done(startup_done));

// file: bench/bdpwm_lamp_model.sv
// Purpose: Lamp inverter, timer capacitor and rate clock beside the PWM
// Assumes: Driven on the falling edge of sys_clk
// Notes: Rate clock is far faster than a real one to keep runs short
`timescale 1ns/1ps
module bdpwm_lamp_model #(
  parameter int DLY = 200
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic lamp_drive_out,
  input wire logic startup_mask_discharge,
  input wire logic ext_en,
  input wire logic broken,
  output logic burst_rate_pin = 1'b0,
  output logic startup_mask_timer_pin = 1'b0,
  output logic open_lamp_sense_in = 1'b1
);
  int chg_q = 0;
  int ph_q = 0;
  // Cap charges from reset and empties on discharge; unlit lamp reads as open
  always @(negedge sys_clk) begin
    chg_q <= (!rst_n || startup_mask_discharge) ? 0 : chg_q + 1;
    startup_mask_timer_pin <= chg_q >= DLY;
    open_lamp_sense_in <= broken || !lamp_drive_out;
  end
  // Ten-cycle rate clock, parked low when unused
  // Bursts run far above 30 to 600 Hz here; only the time scale is compressed
  always @(negedge sys_clk) begin
    ph_q <= (ext_en && ph_q != 9) ? ph_q + 1 : 0;
    burst_rate_pin <= ext_en && ph_q >= 5;
  end
endmodule

// file: bench/burst_dimming_pwm_with_open_lamp_guard_tb.sv
// Purpose: Self-checking bench for the burst dimming PWM
// Assumes: Divider of 4, so one burst is 2048 cycles
// Notes: Duty is measured over one whole burst, which is exact at any phase
`timescale 1ns/1ps
`define CK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module burst_dimming_pwm_with_open_lamp_guard_tb;
  localparam int DIV = 4;
  logic sys_clk = 0, rst_n = 0, ext_en = 0, broken = 0, p = 0;
  logic [7:0] lvl = 8'h00;
  logic rate, tmr, sns, dis, drv, flt, done;
  logic [7:0] lv [8] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'h20, 8'h80, 8'hfe, 8'hff};
  int bad_count = 0, checks_done = 0, seed = 32'h8e41, hi, rises;
  always #12.5 sys_clk = ~sys_clk;
  bdpwm_top #(.OSC_DIV(DIV), .EXT_TIMEOUT(64)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .brightness_level_in(lvl), .burst_rate_pin(rate), .startup_mask_timer_pin(tmr),
    .open_lamp_sense_in(sns), .startup_mask_discharge(dis), .lamp_drive_out(drv),
    .open_lamp_fault(flt), .startup_done(done));
  bdpwm_lamp_model lamp (.sys_clk(sys_clk), .rst_n(rst_n), .lamp_drive_out(drv),
    .startup_mask_discharge(dis), .ext_en(ext_en), .broken(broken), .burst_rate_pin(rate),
    .startup_mask_timer_pin(tmr), .open_lamp_sense_in(sns));
  // Two on-ticks per count below the level, never fewer than the forced 16, and all 512 at full scale 8'hff
  function automatic int exp_ticks(input logic [7:0] l);
    return (l == 8'hff) ? 512 : 2 * ((l < 8'h08) ? 8 : int'(l));
  endfunction
  // Settle one burst so the valley takes the level, then measure the next
  task automatic measure(input logic [7:0] l, input int per);
    lvl = l;
    repeat (512 * per) @(negedge sys_clk);
    // Seed the edge detect from the sample just before the window
    p = drv;
    hi = 0;
    rises = 0;
    repeat (512 * per) begin
      @(negedge sys_clk);
      hi += drv;
      rises += (drv && !p);
      p = drv;
    end
    `CK("on ticks", exp_ticks(l), (hi + per / 2) / per)
    `CK("bursts", (l == 8'hff) ? 0 : 1, rises)
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: duty corners, random levels, rate pin, then the fault path
  initial begin
    repeat (12) @(negedge sys_clk);
    rst_n = 1;
    repeat (50) @(negedge sys_clk);
    `CK("done early", 1'b0, done)
    foreach (lv[i]) measure(lv[i], DIV);
    repeat (4) measure(8'($random(seed)), DIV);
    `CK("discharge", 1'b1, dis)
    `CK("fault idle", 1'b0, flt)
    ext_en = 1;
    measure(8'h40, 10);
    ext_en = 0;
    // Let the low level reach the valley before the lamp breaks
    lvl = 8'h10;
    repeat (1024 * DIV) @(negedge sys_clk);
    broken = 1;
    repeat (1024 * DIV) @(negedge sys_clk);
    `CK("fault low duty", 1'b0, flt)
    lvl = 8'h80;
    repeat (1024 * DIV) @(negedge sys_clk);
    `CK("fault", 1'b1, flt)
    `CK("drive off", 1'b0, drv)
    rst_n = 0;
    repeat (12) @(negedge sys_clk);
    `CK("fault reset", 1'b0, flt)
    // Second release: the minimum on-time starts the first burst at once
    rst_n = 1;
    repeat (2) @(negedge sys_clk);
    `CK("drive after reset", 1'b1, drv)
    `CK("fault after reset", 1'b0, flt)
    print_verdict;
  end
  // Watchdog well past the planned run length
  initial begin
    repeat (95000) @(posedge sys_clk);
    bad_count++;
    print_verdict;
  end
endmodule

// file: design/bdpwm_pkg.sv
// Purpose: Shared constants for the burst dimming PWM with open lamp guard
// Assumes: One 40 MHz system clock, synchronous active-low reset
// Notes: Counts are in dimming DAC clock ticks
package bdpwm_pkg;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] MIN_ON_COUNT = 8'h08;
  localparam logic [7:0] SENSE_DELAY_COUNT = 8'h30;
  localparam logic [7:0] SENSE_MIN_LEVEL = 8'h20;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam int unsigned SYS_CLK_HZ = 40000000;
  localparam int unsigned OSC_HZ_DEFAULT = 128000;
  localparam int unsigned OSC_DIV = SYS_CLK_HZ / OSC_HZ_DEFAULT;
  typedef enum logic {
    BDPWM_DIR_UP,
    BDPWM_DIR_DOWN
  } bdpwm_dir_t;
endpackage

// file: design/bdpwm_tick_gen.sv
// Purpose: Produces the dimming DAC tick from the internal divider or the rate pin
// Assumes: burst_rate_pin is asynchronous and far slower than sys_clk
// Notes: External mode is chosen when pin edges keep arriving
`timescale 1ns/1ps
module bdpwm_tick_gen #(
  parameter int unsigned OSC_DIV = bdpwm_pkg::OSC_DIV,
  parameter int unsigned EXT_TIMEOUT = 4096
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic burst_rate_pin,
  bdpwm_tick_if.src tk
);
  logic [1:0] sync_q;
  logic last_q;
  logic [15:0] div_q;
  logic [15:0] idle_q;
  logic ext_q;
  logic ext_edge;

  // Two-stage synchroniser, then a rising edge detect on the second stage
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync_q <= 2'h0;
      last_q <= 1'h0;
    end else begin
      sync_q <= {sync_q[0], burst_rate_pin};
      last_q <= sync_q[1];
    end
  end
  assign ext_edge = sync_q[1] && !last_q;

  // An applied clock overrides the oscillator; falls back after a silent spell
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      idle_q <= 16'h0000;
      ext_q <= 1'h0;
    end else if (ext_edge) begin
      idle_q <= 16'h0000;
      ext_q <= 1'h1;
    end else if (idle_q == 16'(EXT_TIMEOUT - 1)) begin
      ext_q <= 1'h0;
    end else begin
      idle_q <= idle_q + 16'h0001;
    end
  end

  // Internal oscillator stand-in: a plain divider of the system clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n || div_q == 16'(OSC_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  assign tk.ext_mode = ext_q;
  assign tk.tick = ext_q ? ext_edge : (div_q == 16'(OSC_DIV - 1)); // see (RULE_05) (RULE_06)
endmodule

// file: design/bdpwm_tick_if.sv
// Purpose: Carries the dimming DAC tick between the tick source and the core
// Assumes: Same clock on both sides
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ps
interface bdpwm_tick_if;
  logic tick;
  logic ext_mode;
  modport src (output tick, output ext_mode);
  modport dst (input tick, input ext_mode);
endinterface

// file: design/bdpwm_top.sv
// Purpose: Burst dimming PWM for a lamp inverter with an open lamp guard
// Assumes: Brightness arrives as an 8-bit level already digitised on sys_clk
// Notes: One DAC tick per rate-pin rising edge or divider pulse; 512 ticks per burst
// Overview of operation
// (RULE_01) Output forced high while count below 8
// (RULE_02) Dual slope gives 16 forced counts
// (RULE_03) Duty never below 3.125 percent
// (RULE_04) Duty linear in brightness, full scale 100%
// (RULE_05) Internal burst rate is oscillator over 512
// (RULE_06) Applied rate clock overrides oscillator, over 512
// (RULE_07) System keeps burst rate 30 to 600 Hz
// (RULE_08) Open lamp detection masked until delay ends
// (RULE_09) Timer capacitor released at power on
// (RULE_10) Comparator crossing latched, then discharge asserted
// (RULE_11) Sense evaluated only during on-time
// (RULE_12) Sense starts 48 counts after rising edge
// (RULE_13) Sensing disabled below 12.5 percent duty
// (RULE_14) Open lamp shuts output off
// (RULE_15) Shutdown latched until reset
// (RULE_16) Counter runs up then down, 512 counts
`timescale 1ns/1ps
module bdpwm_top #(
  parameter int unsigned OSC_DIV = bdpwm_pkg::OSC_DIV,
  parameter int unsigned EXT_TIMEOUT = 4096
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] brightness_level_in,
  input wire logic burst_rate_pin,
  input wire logic startup_mask_timer_pin,
  input wire logic open_lamp_sense_in,
  output logic startup_mask_discharge,
  output logic lamp_drive_out,
  output logic open_lamp_fault,
  output logic startup_done
);
  bdpwm_tick_if tk ();
  logic [7:0] cnt_q;
  bdpwm_pkg::bdpwm_dir_t dir_q;
  logic [7:0] level_q;
  logic drive_on;
  logic drive_q;
  logic drive_prev_q;
  logic [7:0] on_cnt_q;
  logic [1:0] dly_sync_q;
  logic [1:0] sns_sync_q;
  logic done_q;
  logic fault_q;
  logic sense_window;

  bdpwm_tick_gen #(
    .OSC_DIV(OSC_DIV),
    .EXT_TIMEOUT(EXT_TIMEOUT)
  ) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .burst_rate_pin(burst_rate_pin),
    .tk(tk)
  );

  // Triangle counter: 256 up plus 256 down ticks make one burst
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= bdpwm_pkg::CNT_RESET;
      dir_q <= bdpwm_pkg::BDPWM_DIR_UP;
    end else if (tk.tick) begin
      case (dir_q)
        bdpwm_pkg::BDPWM_DIR_UP: begin
          if (cnt_q == 8'hff) begin
            dir_q <= bdpwm_pkg::BDPWM_DIR_DOWN; // see (RULE_16)
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        bdpwm_pkg::BDPWM_DIR_DOWN: begin
          if (cnt_q == 8'h00) begin
            dir_q <= bdpwm_pkg::BDPWM_DIR_UP; // see (RULE_16)
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: dir_q <= bdpwm_pkg::BDPWM_DIR_UP;
      endcase
    end
  end

  // Level is sampled at the valley so a burst never sees a torn threshold
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      level_q <= bdpwm_pkg::LEVEL_RESET;
    end else if (tk.tick && cnt_q == 8'h00 && dir_q == bdpwm_pkg::BDPWM_DIR_DOWN) begin
      level_q <= brightness_level_in;
    end
  end

  // On while count is under the level, or under 8 for the minimum duty
  // Full scale 255 still misses one count per slope; treated as 100%
  assign drive_on = (level_q == 8'hff) || (cnt_q < level_q) // see (RULE_04)
                    || (cnt_q < bdpwm_pkg::MIN_ON_COUNT); // see (RULE_01) (RULE_02) (RULE_03)

  // Registered drive, forced off by a latched fault
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_q <= 1'h0;
      drive_prev_q <= 1'h0;
    end else begin
      drive_q <= drive_on && !fault_q; // see (RULE_14)
      drive_prev_q <= drive_q;
    end
  end

  // Counts DAC ticks since the rising edge of the drive
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !drive_q) begin
      on_cnt_q <= 8'h00;
    end else if (drive_q && !drive_prev_q) begin
      on_cnt_q <= 8'h00;
    end else if (tk.tick && on_cnt_q != bdpwm_pkg::SENSE_DELAY_COUNT) begin
      on_cnt_q <= on_cnt_q + 8'h01; // see (RULE_12)
    end
  end

  // Both analog comparator outputs are asynchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dly_sync_q <= 2'h0;
      sns_sync_q <= 2'h0;
    end else begin
      dly_sync_q <= {dly_sync_q[0], startup_mask_timer_pin};
      sns_sync_q <= {sns_sync_q[0], open_lamp_sense_in};
    end
  end

  // End of start-up delay is latched once; discharge follows the latch
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      done_q <= 1'h0; // see (RULE_09)
    end else if (dly_sync_q[1]) begin
      done_q <= 1'h1; // see (RULE_10)
    end
  end
  assign startup_mask_discharge = done_q; // see (RULE_09) (RULE_10)

  // Sense only in on-time, after 48 ticks, after start-up, at 12.5% or more
  assign sense_window = drive_q && done_q // see (RULE_08) (RULE_11)
                        && (on_cnt_q == bdpwm_pkg::SENSE_DELAY_COUNT) // see (RULE_12)
                        && (level_q >= bdpwm_pkg::SENSE_MIN_LEVEL); // see (RULE_13)

  // Sense high means the lamp is not conducting; shutdown sticks until reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fault_q <= 1'h0;
    end else if (sense_window && sns_sync_q[1]) begin
      fault_q <= 1'h1; // see (RULE_14) (RULE_15)
    end
  end

  assign lamp_drive_out = drive_q;
  assign open_lamp_fault = fault_q;
  assign startup_done = done_q;
endmodule
